// ---- hdl/mmpe_edge_engine.sv ----
// pwm edge engine with apb registers and five output modes
`timescale 1ns/1ps
module mmpe_edge_engine
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] filter_duty,
    input wire logic [15:0] filter_period,
    output logic primary_output,
    output logic secondary_output,
    output logic sample_trig_a,
    output logic sample_trig_b,
    output logic phase_trig
);
    localparam int CW = mmpe_pkg::CW;
    localparam int XW = mmpe_pkg::XW;

    // unsigned value widened to the signed working width
    function automatic logic signed [XW-1:0] ux(input logic [CW-1:0] v);
        ux = $signed({3'h0, v});
    endfunction

    // signed value widened to the signed working width
    function automatic logic signed [XW-1:0] sx(input logic [CW-1:0] v);
        sx = $signed({{3{v[CW-1]}}, v});
    endfunction

    // fold a sum back into one period so targets past the end still land
    // only one fold is done: a sum more than a full period out of
    // range lands on a wrong count, which software must avoid
    function automatic logic [CW-1:0] fold(input logic signed [XW-1:0] v,
                                           input logic [CW-1:0] p);
        logic signed [XW-1:0] len;
        logic signed [XW-1:0] r;
        len = ux(p) + 19'sh1;
        r = v;
        if (r < 19'sh0)
            r = r + len;
        else if (r >= len)
            r = r - len;
        fold = r[CW-1:0];
    endfunction

    // reset release through two flops
    // the pin clears both flops at once, but release reaches the
    // logic only after two edges, so no flop leaves reset mid cycle
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // register words written by software
    logic [CW-1:0] regs_q [0:mmpe_pkg::NUM_RW-1];
    // copies taken at the wrap, used for all edge math
    logic [CW-1:0] sh_q [0:mmpe_pkg::NUM_RW-1];
    logic [CW-1:0] duty_q; // filter duty taken at wrap
    logic [CW-1:0] fprd_q; // filter period taken at wrap
    logic [CW-1:0] cnt_q; // period counter
    logic [3:0] idx; // word index of the bus address
    logic mapped; // address hits a word
    logic wr_acc; // write access completing this edge

    assign idx = paddr[5:2];
    assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                    (idx <= mmpe_pkg::IDX_STATUS);
    assign wr_acc = psel && penable && pready && pwrite;

    // software writes; status word is read only
    // a write lands here at once but moves no edge before the next wrap
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            for (int i = 0; i < mmpe_pkg::NUM_RW; i++)
                regs_q[i] <= mmpe_pkg::RST_WORD;
            regs_q[mmpe_pkg::IDX_PERIOD] <= mmpe_pkg::RST_PERIOD;
        end
        else if (wr_acc && mapped && (idx != mmpe_pkg::IDX_STATUS))
            regs_q[idx] <= pwdata[CW-1:0];
    end

    // apb answer: pready rises in the first access cycle, no wait states
    // read data is taken at the setup edge, so the status counter it
    // carries is one cycle older than the access edge
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else if (psel && !penable)
        begin
            // setup cycle: prepare the answer
            pready <= 1'b1;
            pslverr <= !mapped;
            if (!mapped || pwrite)
                prdata <= 32'h0;
            else if (idx == mmpe_pkg::IDX_STATUS)
                prdata <= {14'h0, secondary_output, primary_output, cnt_q};
            else
                prdata <= {16'h0, regs_q[idx]};
        end
        else
        begin
            // answer stands one cycle only
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // decoded controls
    logic run; // engine enabled
    logic ph_sel; // phase trigger taken from filter duty
    mmpe_pkg::mmpe_mode_type mode;
    logic wrap; // counter at its limit this cycle

    assign run = sh_q[mmpe_pkg::IDX_CTRL][mmpe_pkg::CTRL_EN_BIT];
    assign ph_sel = sh_q[mmpe_pkg::IDX_CTRL][mmpe_pkg::CTRL_PH_SEL_BIT];
    assign mode = mmpe_pkg::mmpe_mode_type'(
        sh_q[mmpe_pkg::IDX_CTRL][mmpe_pkg::CTRL_MODE_LO +: 3]);
    assign wrap = (cnt_q >= sh_q[mmpe_pkg::IDX_PERIOD]);

    // period counter; >= also recovers if the limit shrinks
    // a period limit of zero holds the counter at zero every cycle
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            cnt_q <= 16'h0;
        else if (!run || wrap)
            cnt_q <= 16'h0;
        else
            cnt_q <= cnt_q + 16'h1;
    end

    // take new settings only at the wrap or while stopped
    // so no edge moves in the middle of a switching cycle
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            for (int i = 0; i < mmpe_pkg::NUM_RW; i++)
                sh_q[i] <= mmpe_pkg::RST_WORD;
            sh_q[mmpe_pkg::IDX_PERIOD] <= mmpe_pkg::RST_PERIOD;
            duty_q <= 16'h0;
            fprd_q <= 16'h0;
        end
        else if (!run || wrap)
        begin
            for (int i = 0; i < mmpe_pkg::NUM_RW; i++)
                sh_q[i] <= regs_q[i];
            duty_q <= filter_duty;
            fprd_q <= filter_period;
        end
    end

    // working values in the signed domain
    logic signed [XW-1:0] e1, e2, e3, e4;
    logic signed [XW-1:0] adj_a, adj_b, dead_time_compensation, ofs;
    logic signed [XW-1:0] dty, half_dty, half_prd, fprd;
    logic [CW-1:0] period_limit;

    assign period_limit = sh_q[mmpe_pkg::IDX_PERIOD];
    assign e1 = ux(sh_q[mmpe_pkg::IDX_EV1]);
    assign e2 = ux(sh_q[mmpe_pkg::IDX_EV2]);
    assign e3 = ux(sh_q[mmpe_pkg::IDX_EV3]);
    assign e4 = ux(sh_q[mmpe_pkg::IDX_EV4]);
    assign adj_a = sx(sh_q[mmpe_pkg::IDX_CADJ_A]);
    assign adj_b = sx(sh_q[mmpe_pkg::IDX_CADJ_B]);
    assign dead_time_compensation = sx(sh_q[mmpe_pkg::IDX_DTC]);
    assign ofs = sx(sh_q[mmpe_pkg::IDX_SMP_OFS]);
    assign dty = ux(duty_q);
    assign half_dty = ux({1'b0, duty_q[CW-1:1]});
    assign half_prd = ux({1'b0, period_limit[CW-1:1]});
    assign fprd = ux(fprd_q);

    // edge targets per mode
    // sums stay signed and three bits wider, so negative targets and
    // sums past the period fold instead of wrapping at sixteen bits
    logic signed [XW-1:0] a_rise, a_fall, b_rise, b_fall, t_a, t_b;
    logic a_on, b_on, trig_on; // which edges exist in this mode
    logic b_cross; // B may run over the wrap

    always_comb
    begin
        a_rise = e1;
        a_fall = e1 + dty + adj_a;
        b_rise = a_fall + (e3 - e2);
        b_fall = e4 + dead_time_compensation;
        t_a = e1 + dty + ofs;
        t_b = e1 + half_dty + ofs;
        a_on = 1'b1;
        b_on = 1'b1;
        trig_on = 1'b1;
        b_cross = 1'b0;
        case (mode)
            mmpe_pkg::MMPE_NORMAL:
            begin
                // defaults above; adjust B never used
                a_fall = e1 + dty + adj_a;
                b_rise = a_fall + (e3 - e2);
                t_a = e1 + dty + ofs;
            end
            mmpe_pkg::MMPE_MULTI:
            begin
                // events two and four take no part here
                a_fall = e1 + dty + adj_a + dead_time_compensation;
                b_rise = e3;
                b_fall = e3 + dty + adj_b + dead_time_compensation;
                b_cross = 1'b1;
            end
            mmpe_pkg::MMPE_RESONANT:
            begin
                // filter period set to twice duty; event 1 acts as half the
                // dead time, so both on-times are duty minus twice it
                a_fall = dty - e1;
                b_rise = dty + e1;
                b_fall = fprd - e1;
            end
            mmpe_pkg::MMPE_TRIANGLE:
            begin
                a_on = 1'b0;
                trig_on = 1'b0;
                b_rise = half_prd - half_dty + adj_a;
                b_fall = half_prd + half_dty + adj_b;
            end
            mmpe_pkg::MMPE_LEADING:
            begin
                // moving edge leads the fixed event 1 edge
                a_rise = e1 - dty + adj_a;
                a_fall = e1;
                b_rise = e4;
                b_fall = e1 - dty + adj_a - (e2 - e3);
                t_a = e1 - dty + ofs;
                t_b = e1 - half_dty + ofs;
            end
            default:
            begin
                // unused mode codes drive neither output nor a sample trigger
                a_on = 1'b0;
                b_on = 1'b0;
                trig_on = 1'b0;
            end
        endcase
    end

    // comparisons against the running counter
    // each hit fires when the counter equals the target, not earlier: the registered outputs
    // then change one clock after the counter equals the target
    logic a_rise_hit, a_fall_hit, b_rise_hit, b_fall_hit;
    logic ta_hit, tb_hit, ph_hit;
    logic [CW-1:0] ph_target;

    assign a_rise_hit = (cnt_q == fold(a_rise, period_limit));
    assign a_fall_hit = (cnt_q == fold(a_fall, period_limit));
    assign b_rise_hit = (cnt_q == fold(b_rise, period_limit));
    assign b_fall_hit = (cnt_q == fold(b_fall, period_limit));
    assign ta_hit = (cnt_q == fold(t_a, period_limit));
    assign tb_hit = (cnt_q == fold(t_b, period_limit));
    assign ph_target = ph_sel ? duty_q : sh_q[mmpe_pkg::IDX_PH_TRIG];
    assign ph_hit = (cnt_q == ph_target);

    // output A never crosses the period end
    mmpe_edge_cell u_cell_a
    (
        .clock(clock),
        .rst_n(rst_n_q),
        .use_cell(run && a_on),
        .rise_hit(a_rise_hit),
        .fall_hit(a_fall_hit),
        .wrap_clr(wrap),
        .level_q(primary_output)
    );

    // output B crosses the wrap only in multi mode, keeping its width
    mmpe_edge_cell u_cell_b
    (
        .clock(clock),
        .rst_n(rst_n_q),
        .use_cell(run && b_on),
        .rise_hit(b_rise_hit),
        .fall_hit(b_fall_hit),
        .wrap_clr(wrap && !b_cross),
        .level_q(secondary_output)
    );

    // trigger pulses, one cycle, registered
    // gating with run keeps a stale target from firing while stopped
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sample_trig_a <= 1'b0;
            sample_trig_b <= 1'b0;
            phase_trig <= 1'b0;
        end
        else
        begin
            sample_trig_a <= run && trig_on && ta_hit;
            sample_trig_b <= run && trig_on && tb_hit;
            phase_trig <= run && ph_hit;
        end
    end
endmodule

// ---- include/mmpe_pkg.sv ----
// constants for the multi mode pwm edge engine
package mmpe_pkg;
    // data widths
    localparam int CW = 16; // counter and edge value width
    localparam int XW = 19; // signed working width for edge sums
    // register word indexes, byte address is index times four
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_PERIOD = 4'h1;
    localparam logic [3:0] IDX_EV1 = 4'h2;
    localparam logic [3:0] IDX_EV2 = 4'h3;
    localparam logic [3:0] IDX_EV3 = 4'h4;
    localparam logic [3:0] IDX_EV4 = 4'h5;
    localparam logic [3:0] IDX_CADJ_A = 4'h6;
    localparam logic [3:0] IDX_CADJ_B = 4'h7;
    localparam logic [3:0] IDX_DTC = 4'h8;
    localparam logic [3:0] IDX_SMP_OFS = 4'h9;
    localparam logic [3:0] IDX_PH_TRIG = 4'ha;
    localparam logic [3:0] IDX_STATUS = 4'hb;
    localparam int NUM_RW = 11; // writable words, index 0 to 10
    // byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    // control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_PH_SEL_BIT = 4;
    // status field positions
    localparam int STAT_A_BIT = 16;
    localparam int STAT_B_BIT = 17;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'h00ff;
    // output modes
    typedef enum logic [2:0] {
        MMPE_NORMAL = 3'h0,
        MMPE_MULTI = 3'h1,
        MMPE_RESONANT = 3'h2,
        MMPE_TRIANGLE = 3'h3,
        MMPE_LEADING = 3'h4
    } mmpe_mode_type;
endpackage

// ---- hdl/mmpe_edge_cell.sv ----
// set and clear cell holding one pwm output level
`timescale 1ns/1ps
module mmpe_edge_cell
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic use_cell,
    input wire logic rise_hit,
    input wire logic fall_hit,
    input wire logic wrap_clr,
    output logic level_q
);
    // level follows the edges; fall wins a tie so equal targets give no pulse
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            level_q <= 1'b0;
        else if (!use_cell)
            level_q <= 1'b0; // output idle in this mode
        else if (fall_hit)
            level_q <= 1'b0;
        else if (rise_hit)
            level_q <= 1'b1;
        else if (wrap_clr)
            level_q <= 1'b0; // pulse may not cross the period end
    end
endmodule

// ---- verif/mmpe_edge_engine_properties.sv ----
// port level assertions for the pwm edge engine
`timescale 1ns/1ps
module mmpe_edge_engine_checker
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] filter_duty,
    input wire logic [15:0] filter_period,
    input wire logic primary_output,
    input wire logic secondary_output,
    input wire logic sample_trig_a,
    input wire logic sample_trig_b,
    input wire logic phase_trig
);
    logic [4:0] ctrl_q; // shadow of control bits
    logic [15:0] prd_q; // shadow of period limit
    logic [1:0] seen_q; // phase triggers since last write
    logic [16:0] gap_q; // cycles since last phase trigger
    logic tri_on; // triangular mode settled
    logic [16:0] off_q; // cycles spent disabled, saturating
    // shadows follow completed writes; any write restarts settling, since
    // new values only land at the next wrap
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= 5'h00;
            prd_q <= 16'h00ff;
            seen_q <= 2'h0;
            gap_q <= 17'h00000;
            off_q <= 17'h00000;
        end
        else
        begin
            if (psel && penable && pready && pwrite && paddr == 8'h00)
                ctrl_q <= pwdata[4:0];
            if (psel && penable && pready && pwrite && paddr == 8'h04)
                prd_q <= pwdata[15:0];
            if (psel && penable && pready && pwrite)
                seen_q <= 2'h0;
            else if (phase_trig && seen_q != 2'h3)
                seen_q <= seen_q + 2'h1;
            gap_q <= phase_trig ? 17'h00000 : gap_q + 17'h00001;
            // a stop only lands at the next wrap, so count the whole period
            if (ctrl_q[0])
                off_q <= 17'h00000;
            else if (off_q != 17'h1ffff)
                off_q <= off_q + 17'h00001;
        end
    end
    assign tri_on = ctrl_q[0] && ctrl_q[3:1] == 3'h3 && seen_q == 2'h3;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_ready_after_setup; psel && !penable |=> pready && penable; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_unmapped; psel && !penable && (paddr > 8'h2c || paddr[1:0] != 2'h0) |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_trig_pulse; sample_trig_a |=> !sample_trig_a; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("sample trigger not a pulse");
    property p_phase_gap; phase_trig && seen_q == 2'h3 && ctrl_q[0] && !ctrl_q[4] |-> gap_q == {1'b0, prd_q}; endproperty
    a_phase_gap: assert property (p_phase_gap) else $error("switching cycle length wrong");
    property p_tri_no_primary; tri_on |-> !primary_output; endproperty
    a_tri_no_primary: assert property (p_tri_no_primary) else $error("output a active in triangle");
    property p_tri_no_samples; tri_on |-> !sample_trig_a && !sample_trig_b; endproperty
    a_tri_no_samples: assert property (p_tri_no_samples) else $error("sample trigger in triangle");
    property p_off_quiet;
        off_q > {1'b0, prd_q} + 17'h00002 |-> !primary_output && !secondary_output && !phase_trig;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("outputs active while disabled");
endmodule
bind mmpe_edge_engine mmpe_edge_engine_checker u_chk (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .filter_duty(filter_duty), .filter_period(filter_period),
    .primary_output(primary_output), .secondary_output(secondary_output),
    .sample_trig_a(sample_trig_a), .sample_trig_b(sample_trig_b), .phase_trig(phase_trig));

// ---- verif/mmpe_gate_driver_model.sv ----
// gate driver model stamping edge positions against the phase trigger
`timescale 1ns/1ps
module mmpe_gate_driver_model
(
    input wire logic clock,
    input wire logic primary_output,
    input wire logic secondary_output,
    input wire logic sample_trig_a,
    input wire logic sample_trig_b,
    input wire logic phase_trig,
    output int pos_o[6],
    output int len_o
);
    int cur[6] = '{default: -1}; // stamps of this cycle, -1 when absent
    int at = 0; // cycles since phase trigger
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    // both edges and pulses are registered, so stamps equal target values
    always @(posedge clock)
    begin
        if (phase_trig === 1'b1)
        begin
            pos_o <= cur;
            len_o <= at + 1;
            cur = '{default: -1};
            at = 0;
        end
        else
            at = at + 1;
        if (primary_output === 1'b1 && a_q === 1'b0)
            cur[0] = at;
        if (primary_output === 1'b0 && a_q === 1'b1)
            cur[1] = at;
        if (secondary_output === 1'b1 && b_q === 1'b0)
            cur[2] = at;
        if (secondary_output === 1'b0 && b_q === 1'b1)
            cur[3] = at;
        if (sample_trig_a === 1'b1)
            cur[4] = at;
        if (sample_trig_b === 1'b1)
            cur[5] = at;
        a_q = primary_output;
        b_q = secondary_output;
    end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the pwm edge engine
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [2:0] mode; int e1; int e4; int duty; int fper; int exp[6];} mmpe_row_type;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] filter_duty = 16'h0000;
    logic [15:0] filter_period = 16'h0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pa, pb, ta, tb, ph, er;
    int pos[6];
    int len;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    string pn[6] = '{"rise_a", "fall_a", "rise_b", "fall_b", "trig_a", "trig_b"};
    mmpe_row_type rows[6];
    mmpe_edge_engine u_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .filter_duty(filter_duty), .filter_period(filter_period), .primary_output(pa),
        .secondary_output(pb), .sample_trig_a(ta), .sample_trig_b(tb), .phase_trig(ph));
    mmpe_gate_driver_model u_drv (.clock(clock), .primary_output(pa), .secondary_output(pb),
        .sample_trig_a(ta), .sample_trig_b(tb), .phase_trig(ph), .pos_o(pos), .len_o(len));
    // 250 MHz clock
    always #2 clock = ~clock;
    // hang guard, well above the expected few thousand cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_pos(input string n, input int e, input int g);
        cmp_count++;
        if (e != g)
        begin
            errors++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, entered just after an edge; idle cycle afterwards
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin @(posedge clock); end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        apb(1'b1, {2'h0, i, 2'h0}, d);
    endtask
    // wait for n phase triggers, then one edge so the stamps have landed
    task automatic wait_ph(input int n);
        repeat (n)
        begin
            do begin @(posedge clock); end while (ph !== 1'b1);
        end
        @(posedge clock);
    endtask
    task automatic run_row(input mmpe_row_type r);
        wr(mmpe_pkg::IDX_EV1, 32'(r.e1));
        wr(mmpe_pkg::IDX_EV4, 32'(r.e4));
        filter_duty <= 16'(r.duty);
        filter_period <= 16'(r.fper);
        wr(mmpe_pkg::IDX_CTRL, {28'h0000000, r.mode, 1'b1});
        wait_ph(3);
    endtask
    initial
    begin
        // event2 20, event3 25, adjust a 2, adjust b 3, dtc 1, offset -4, period 100
        rows = '{'{3'h0, 10, 90, 30, 60, '{10, 42, 47, 91, 36, 21}},
            '{3'h1, 10, 5, 30, 60, '{10, 43, 25, 59, 36, 21}},
            '{3'h2, 10, 90, 40, 80, '{10, 30, 50, 70, 46, 26}},
            '{3'h3, 10, 90, 30, 60, '{-1, -1, 37, 68, -1, -1}},
            '{3'h4, 70, 5, 30, 60, '{42, 70, 5, 47, 36, 51}},
            '{3'h1, 10, 90, 80, 60, '{10, 93, 25, 8, 86, 46}}};
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        chk_word("outputs after reset", 32'h00000000, {27'h0000000, pa, pb, ta, tb, ph});
        apb(1'b0, 8'h04, 32'h00000000);
        chk_word("period reset value", 32'h000000ff, rd);
        apb(1'b0, 8'hfc, 32'h00000000);
        chk_word("unmapped error", 32'h00000001, {31'h00000000, er});
        wr(mmpe_pkg::IDX_SMP_OFS, 32'hfffffffc);
        apb(1'b0, 8'h24, 32'h00000000);
        chk_word("offset readback", 32'h0000fffc, rd);
        wr(mmpe_pkg::IDX_PERIOD, 32'h00000064);
        wr(mmpe_pkg::IDX_EV2, 32'h00000014);
        wr(mmpe_pkg::IDX_EV3, 32'h00000019);
        wr(mmpe_pkg::IDX_CADJ_A, 32'h00000002);
        wr(mmpe_pkg::IDX_CADJ_B, 32'h00000003);
        wr(mmpe_pkg::IDX_DTC, 32'h00000001);
        wr(mmpe_pkg::IDX_PH_TRIG, 32'h00000000);
        foreach (rows[i])
        begin
            run_row(rows[i]);
            for (int j = 0; j < 6; j++)
                chk_pos(pn[j], rows[i].exp[j], pos[j]);
            chk_pos("cycle length", 101, len);
        end
        // phase trigger taken from duty, so stamps shift by 30
        run_row(rows[0]);
        wr(mmpe_pkg::IDX_CTRL, 32'h00000011);
        wait_ph(3);
        chk_pos("rise_a by duty", 81, pos[0]);
        chk_pos("fall_a by duty", 12, pos[1]);
        // duty changed mid cycle must wait for the wrap
        wr(mmpe_pkg::IDX_CTRL, 32'h00000001);
        wait_ph(3);
        repeat (20) @(posedge clock);
        filter_duty <= 16'h0032;
        wait_ph(1);
        chk_pos("fall_a old duty", 42, pos[1]);
        wait_ph(1);
        chk_pos("fall_a new duty", 62, pos[1]);
        // spare mode code: counter and phase trigger run but both outputs and sample triggers stay idle
        wr(mmpe_pkg::IDX_CTRL, 32'h0000000b);
        wait_ph(3);
        for (int j = 0; j < 6; j++)
            chk_pos(pn[j], -1, pos[j]);
        chk_pos("cycle length", 101, len);
        // the stop lands only at the next wrap, up to a full period later
        wr(mmpe_pkg::IDX_CTRL, 32'h00000000);
        repeat (110) @(posedge clock);
        apb(1'b0, 8'h2c, 32'h00000000);
        chk_word("status when off", 32'h00000000, rd);
        chk_word("outputs when off", 32'h00000000, {27'h0000000, pa, pb, ta, tb, ph});
        wrap_up();
    end
endmodule
